/* rtl/its_seq.sv */
// input trigger sequencer: source, delay and measure phases under trigger
// assumes AHB-Lite master on clk, asynchronous trigger and button pins
`timescale 1ns/1ns
module its_seq
  import its_pkg::*;
#(
  parameter int unsigned BLINK_HALF = BLINK_HALF_CYC
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // trigger pins
  input  wire logic        trig_in_n,
  input  wire logic        button_n,
  // sequencer outputs
  output its_out_s         seq_sig
);

  typedef struct packed {
    its_bus_s bus;
    its_cfg_s cfg;
    its_seq_s seq;
  } its_top_s;

  its_top_s q_ff;
  its_top_s nxt_q;
  logic     pin_fall;
  logic     btn_fall;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  its_pin_sync u_pin_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .pin_n (trig_in_n),
    .fall  (pin_fall)
  );

  its_pin_sync u_btn_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .pin_n (button_n),
    .fall  (btn_fall)
  );

  // ---------------------------------------------------------------
  // decoding helpers
  // ---------------------------------------------------------------
  function automatic logic cont_like(its_mode_e m, logic sweep);
    cont_like = (m == MODE_CONTINUOUS) || (m == MODE_PULSE_PAIR && !sweep);
  endfunction

  // bit 0 source, bit 1 delay, bit 2 measure: trigger needed before phase
  function automatic logic need_before(its_cfg_s c, its_phase_e p, logic [15:0] idx);
    logic [2:0] mask;
    mask = 3'h0;
    case (c.mode)
      MODE_PER_TRIGGER_FULL_CYCLE:          mask = 3'h1;
      MODE_STAGGERED_SOURCE_FIRST:          mask = 3'h2;
      MODE_SPLIT_SOURCE_THEN_DELAY_MEASURE: mask = 3'h3;
      MODE_STAGGERED_SOURCE_DELAY_FIRST:    mask = 3'h4;
      MODE_SPLIT_SOURCE_DELAY_THEN_MEASURE: mask = 3'h5;
      MODE_STAGGERED_THREE_PHASE:           mask = 3'h6;
      MODE_PER_PHASE_TRIGGER:               mask = 3'h7;
      MODE_PULSE_PAIR:                      mask = {2'h0, c.sweep & ~idx[0]};
      default:                              mask = 3'h0;
    endcase
    case (p)
      PH_SOURCE:  need_before = mask[0];
      PH_DELAY:   need_before = mask[1];
      PH_MEASURE: need_before = mask[2];
      default:    need_before = !cont_like(c.mode, c.sweep);
    endcase
  endfunction

  function automatic its_seq_s start_ph(its_seq_s s, its_cfg_s c, its_phase_e p);
    logic [15:0] lvl;
    lvl    = c.sweep ? ((s.idx == 16'h0000) ? c.src_pend : 16'(s.lvl + c.step)) : c.src_pend;
    s.st   = ST_RUN;
    s.ph   = p;
    case (p)
      PH_SOURCE: begin
        s.lvl     = lvl;
        s.applied = lvl;  // pending level reaches output only here
        s.at_bias = 1'b0;
        s.timer   = SRC_TIMER_LD;
      end
      PH_DELAY: begin
        s.timer = c.delay;
      end
      PH_MEASURE: begin
        s.timer = MEAS_TIMER_LD;
      end
      default: begin
        s.applied = c.bias;
        s.at_bias = 1'b1;
        s.timer   = 16'h0000;
      end
    endcase
    start_ph = s;
  endfunction

  function automatic logic [31:0] rd_word(logic [7:0] a, its_top_s t);
    logic [31:0] w;
    w = 32'h0000_0000;
    case (a)
      REG_CTRL: begin
        w[CTRL_MODE_LSB +: 4] = t.cfg.mode;
        w[CTRL_SWEEP]         = t.cfg.sweep;
        w[CTRL_OPERATE]       = t.cfg.operate;
        w[CTRL_TRIG_EN]       = t.cfg.trig_en;
        w[CTRL_EXT_ORG]       = t.cfg.ext_org;
      end
      REG_SRC:    w[15:0] = t.cfg.src_pend;
      REG_BIAS:   w[15:0] = t.cfg.bias;
      REG_STEP:   w[15:0] = t.cfg.step;
      REG_POINTS: w[15:0] = t.cfg.points;
      REG_DELAY:  w[15:0] = t.cfg.delay;
      REG_STATUS: begin
        w[STAT_ERR]            = t.seq.err;
        w[STAT_LAMP]           = seq_sig.lamp;
        w[STAT_BLANK]          = t.seq.blank;
        w[STAT_RUNNING]        = t.seq.st == ST_RUN;
        w[STAT_WAITING]        = t.seq.st != ST_RUN;
        w[STAT_AT_BIAS]        = t.seq.at_bias;
        w[STAT_PH_LSB +: 2]    = t.seq.ph;
        w[STAT_IDX_LSB +: 16]  = t.seq.idx;
      end
      REG_LEVEL:  w[15:0] = t.seq.applied;
      default:    w = 32'h0000_0000;
    endcase
    rd_word = w;
  endfunction

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic       wr;
    logic       trig;
    logic       abort;
    logic       ss_dc;
    logic       last;
    its_mode_e  new_mode;
    its_phase_e p_nx;
    its_seq_s   s;
    nxt_q    = q_ff;
    wr       = q_ff.bus.a_valid & q_ff.bus.a_write;
    new_mode = its_mode_e'(hwdata[CTRL_MODE_LSB +: 4]);
    ss_dc    = !q_ff.cfg.sweep && !cont_like(q_ff.cfg.mode, q_ff.cfg.sweep);
    last     = 1'b0;
    p_nx     = PH_SOURCE;
    trig     = 1'b0;
    abort    = 1'b0;
    s        = q_ff.seq;

    // bus address and data phases
    nxt_q.bus.a_valid = 1'b0;
    nxt_q.bus.rd_wait = 1'b0;
    if (q_ff.bus.rd_wait) begin
      nxt_q.bus.hrdata = rd_word(q_ff.bus.a_addr, q_ff);
    end
    if (hsel && hready && htrans[1]) begin
      nxt_q.bus.a_valid = 1'b1;
      nxt_q.bus.a_write = hwrite;
      nxt_q.bus.a_addr  = haddr[7:0];
      nxt_q.bus.rd_wait = !hwrite;
    end
    if (wr) begin
      case (q_ff.bus.a_addr)
        REG_CTRL: begin
          nxt_q.cfg.mode    = new_mode;
          nxt_q.cfg.sweep   = hwdata[CTRL_SWEEP];
          nxt_q.cfg.operate = hwdata[CTRL_OPERATE];
          nxt_q.cfg.trig_en = hwdata[CTRL_TRIG_EN];
          nxt_q.cfg.ext_org = hwdata[CTRL_EXT_ORG];
        end
        REG_SRC:    nxt_q.cfg.src_pend = hwdata[15:0];
        REG_BIAS:   nxt_q.cfg.bias     = hwdata[15:0];
        REG_STEP:   nxt_q.cfg.step     = hwdata[15:0];
        REG_POINTS: nxt_q.cfg.points   = hwdata[15:0];
        REG_DELAY:  nxt_q.cfg.delay    = hwdata[15:0];
        REG_TRIG:   if (hwdata[TRIG_ERR_CLR]) nxt_q.seq.err = 1'b0;
        default:    nxt_q.cfg = nxt_q.cfg;
      endcase
    end

    // trigger gathering and abort causes
    trig  = q_ff.cfg.trig_en & (btn_fall | (q_ff.cfg.ext_org & pin_fall) |
            (wr && q_ff.bus.a_addr == REG_TRIG && hwdata[TRIG_SOFT]));
    abort = ss_dc & wr & ((q_ff.bus.a_addr == REG_SRC) || (q_ff.bus.a_addr == REG_STEP) ||
            (q_ff.bus.a_addr == REG_POINTS) ||
            (q_ff.bus.a_addr == REG_TRIG && hwdata[TRIG_SETTING]) ||
            (q_ff.bus.a_addr == REG_CTRL && new_mode != q_ff.cfg.mode &&
             !cont_like(new_mode, q_ff.cfg.sweep)));

    // sequencer
    s            = nxt_q.seq;
    s.meas_stb   = 1'b0;
    if (!nxt_q.cfg.trig_en) begin  // stops at the same edge as the disabling write
      s.st        = ST_IDLE;
      s.ph        = PH_SOURCE;
      s.need_trig = 1'b1;
    end else if (abort) begin
      s.st    = ST_IDLE;
      s.ph    = PH_SOURCE;
      s.blank = 1'b1;
    end else begin
      case (q_ff.seq.st)
        ST_IDLE: begin
          if (trig || (cont_like(q_ff.cfg.mode, q_ff.cfg.sweep) && !q_ff.cfg.sweep &&
                       q_ff.cfg.operate && !q_ff.seq.need_trig)) begin
            s.need_trig = 1'b0;
            s.idx       = 16'h0000;
            s           = start_ph(s, q_ff.cfg, PH_SOURCE);
          end
        end
        ST_WAIT: begin
          if (trig) begin
            s = start_ph(s, q_ff.cfg, q_ff.seq.ph);
          end
        end
        ST_RUN: begin
          if (trig) begin
            s.err = 1'b1;  // set wins over clear, trigger dropped
          end
          if (q_ff.seq.timer != 16'h0000) begin
            s.timer = 16'(q_ff.seq.timer - 16'h0001);
          end else begin
            case (q_ff.seq.ph)
              PH_SOURCE: p_nx = PH_DELAY;
              PH_DELAY:  p_nx = PH_MEASURE;
              PH_MEASURE: begin
                s.meas_stb   = 1'b1;
                s.meas_point = q_ff.seq.idx;
                s.blank      = 1'b0;
                last = q_ff.cfg.sweep && (q_ff.seq.idx >= 16'(q_ff.cfg.points - 16'h0001));
                if (last) begin
                  p_nx = PH_BIAS;
                end else begin
                  p_nx  = PH_SOURCE;
                  s.idx = q_ff.cfg.sweep ? 16'(q_ff.seq.idx + 16'h0001) : q_ff.seq.idx;
                end
              end
              default: begin
                s.st  = ST_IDLE;
                s.ph  = PH_SOURCE;
                s.idx = 16'h0000;
              end
            endcase
            if (q_ff.seq.ph != PH_BIAS) begin
              if (need_before(q_ff.cfg, p_nx, s.idx)) begin
                s.st = ST_WAIT;
                s.ph = p_nx;
              end else begin
                s = start_ph(s, q_ff.cfg, p_nx);
              end
            end
          end
        end
        default: begin
          s.st = ST_IDLE;
          s.ph = PH_SOURCE;
        end
      endcase
    end

    // lamp blink timebase
    if (s.blink_cnt == BLINK_W'(BLINK_HALF - 1)) begin
      s.blink_cnt = '0;
      s.blink     = ~q_ff.seq.blink;
    end else begin
      s.blink_cnt = BLINK_W'(q_ff.seq.blink_cnt + 1'b1);
    end
    nxt_q.seq = s;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q_ff              <= '0;  // idle, source phase, error clear
      q_ff.cfg.mode     <= its_mode_e'(CTRL_RST[CTRL_MODE_LSB +: 4]);
      q_ff.cfg.sweep    <= CTRL_RST[CTRL_SWEEP];
      q_ff.cfg.operate  <= CTRL_RST[CTRL_OPERATE];
      q_ff.cfg.trig_en  <= CTRL_RST[CTRL_TRIG_EN];
      q_ff.cfg.ext_org  <= CTRL_RST[CTRL_EXT_ORG];
      q_ff.cfg.points   <= POINTS_RST;
      q_ff.seq.applied  <= LEVEL_RST;
      q_ff.seq.at_bias  <= 1'b1;
    end else begin
      q_ff <= nxt_q;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign hrdata    = q_ff.bus.hrdata;
  assign hreadyout = !q_ff.bus.rd_wait;
  assign hresp     = 1'b0;

  always_comb begin
    seq_sig               = '0;
    seq_sig.src_level     = q_ff.seq.applied;
    seq_sig.at_bias       = q_ff.seq.at_bias;
    seq_sig.phase         = q_ff.seq.ph;
    seq_sig.busy          = q_ff.seq.st == ST_RUN;
    seq_sig.meas_strobe   = q_ff.seq.meas_stb;
    seq_sig.meas_point    = q_ff.seq.meas_point;
    seq_sig.display_blank = q_ff.seq.blank;
    seq_sig.trig_err      = q_ff.seq.err;
    seq_sig.lamp          = q_ff.cfg.trig_en &
                            ((q_ff.seq.st == ST_RUN) ||
                             (q_ff.seq.st == ST_IDLE && !q_ff.cfg.sweep && !q_ff.seq.need_trig &&
                              cont_like(q_ff.cfg.mode, q_ff.cfg.sweep)) ||
                             q_ff.seq.blink);
  end

endmodule

/* pkg/its_pkg.sv */
// shared constants, register map and types of the input trigger sequencer
// assumes a 50 MHz system clock and a 32-bit AHB-Lite register port
package its_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ         = 50_000_000;
  localparam int unsigned CLK_MHZ        = CLK_HZ / 1_000_000;
  localparam int unsigned SRC_TIME_NS    = 1_000;
  localparam int unsigned MEAS_TIME_NS   = 2_000;
  localparam int unsigned BLINK_HALF_US  = 250_000;
  localparam int unsigned SRC_CYC        = (SRC_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned MEAS_CYC       = (MEAS_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned BLINK_HALF_CYC = BLINK_HALF_US * CLK_MHZ;
  localparam int unsigned BLINK_W        = 24;
  localparam logic [15:0] SRC_TIMER_LD   = 16'(SRC_CYC - 1);
  localparam logic [15:0] MEAS_TIMER_LD  = 16'(MEAS_CYC - 1);

  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_TRIG   = 8'h04;
  localparam logic [7:0] REG_SRC    = 8'h08;
  localparam logic [7:0] REG_BIAS   = 8'h0C;
  localparam logic [7:0] REG_STEP   = 8'h10;
  localparam logic [7:0] REG_POINTS = 8'h14;
  localparam logic [7:0] REG_DELAY  = 8'h18;
  localparam logic [7:0] REG_STATUS = 8'h1C;
  localparam logic [7:0] REG_LEVEL  = 8'h20;

  // ctrl fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_SWEEP    = 4;
  localparam int CTRL_OPERATE  = 5;
  localparam int CTRL_TRIG_EN  = 6;
  localparam int CTRL_EXT_ORG  = 7;
  // trig fields (write only, self clearing)
  localparam int TRIG_SOFT     = 0;
  localparam int TRIG_SETTING  = 1;
  localparam int TRIG_ERR_CLR  = 2;
  // status fields
  localparam int STAT_ERR      = 0;
  localparam int STAT_LAMP     = 1;
  localparam int STAT_BLANK    = 2;
  localparam int STAT_RUNNING  = 3;
  localparam int STAT_WAITING  = 4;
  localparam int STAT_AT_BIAS  = 5;
  localparam int STAT_PH_LSB   = 8;
  localparam int STAT_IDX_LSB  = 16;

  // reset values
  localparam logic [7:0]  CTRL_RST   = 8'h40;
  localparam logic [15:0] LEVEL_RST  = 16'h0000;
  localparam logic [15:0] POINTS_RST = 16'h0001;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    MODE_CONTINUOUS,
    MODE_PER_TRIGGER_FULL_CYCLE,
    MODE_STAGGERED_SOURCE_FIRST,
    MODE_SPLIT_SOURCE_THEN_DELAY_MEASURE,
    MODE_STAGGERED_SOURCE_DELAY_FIRST,
    MODE_SPLIT_SOURCE_DELAY_THEN_MEASURE,
    MODE_STAGGERED_THREE_PHASE,
    MODE_PER_PHASE_TRIGGER,
    MODE_PULSE_PAIR
  } its_mode_e;

  typedef enum logic [1:0] {
    PH_SOURCE,
    PH_DELAY,
    PH_MEASURE,
    PH_BIAS
  } its_phase_e;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT,
    ST_RUN
  } its_state_e;

  typedef struct packed {
    logic [15:0] src_level;
    logic        at_bias;
    its_phase_e  phase;
    logic        busy;
    logic        meas_strobe;
    logic [15:0] meas_point;
    logic        display_blank;
    logic        lamp;
    logic        trig_err;
  } its_out_s;

  typedef struct packed {
    logic       a_valid;
    logic       a_write;
    logic [7:0] a_addr;
    logic       rd_wait;
    logic [31:0] hrdata;
  } its_bus_s;

  typedef struct packed {
    its_mode_e   mode;
    logic        sweep;
    logic        operate;
    logic        trig_en;
    logic        ext_org;
    logic [15:0] src_pend;
    logic [15:0] bias;
    logic [15:0] step;
    logic [15:0] points;
    logic [15:0] delay;
  } its_cfg_s;

  typedef struct packed {
    its_state_e   st;
    its_phase_e   ph;
    logic [15:0]  timer;
    logic [15:0]  idx;
    logic [15:0]  lvl;
    logic [15:0]  applied;
    logic         at_bias;
    logic         need_trig;
    logic         blank;
    logic         err;
    logic         meas_stb;
    logic [15:0]  meas_point;
    logic [BLINK_W-1:0] blink_cnt;
    logic         blink;
  } its_seq_s;

endpackage

/* rtl/its_pin_sync.sv */
// two-stage synchroniser and falling edge detector for a trigger pin
// assumes the pin is asynchronous and its low pulse lasts over two clocks
`timescale 1ns/1ns
module its_pin_sync (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // pin and event
  input  wire logic pin_n,
  output logic      fall
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic prev;
    logic fall;
  } its_sync_s;

  its_sync_s q_ff;
  its_sync_s nxt_q;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    nxt_q      = q_ff;
    nxt_q.s1   = pin_n;
    nxt_q.s2   = q_ff.s1;
    nxt_q.prev = q_ff.s2;
    nxt_q.fall = q_ff.prev & ~q_ff.s2;  // one event per low pulse
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q_ff <= '{s1: 1'b1, s2: 1'b1, prev: 1'b1, fall: 1'b0};
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign fall = q_ff.fall;

endmodule

/* testbench/its_seq_properties.sv */
// concurrent checks on the ports of the input trigger sequencer
// assumes one bus slave, so hready is the design's own hreadyout
`timescale 1ns/1ns
module its_seq_properties
  import its_pkg::*;
#(
  parameter int unsigned BLINK_HALF = 8
) (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // ahb-lite
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // pins and sequencer outputs
  input wire logic        trig_in_n,
  input wire logic        button_n,
  input wire its_out_s    seq_sig
);
  // ---------------------------------------------------------------
  // phase length counters
  // ---------------------------------------------------------------
  logic [7:0] src_cnt_ff;
  logic [7:0] meas_cnt_ff;
  logic       in_src;
  logic       in_meas;
  logic       rd_take;
  assign in_src  = seq_sig.busy && seq_sig.phase == PH_SOURCE;
  assign in_meas = seq_sig.busy && seq_sig.phase == PH_MEASURE;
  assign rd_take = hsel && hready && htrans[1] && !hwrite;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      src_cnt_ff  <= 8'h00;
      meas_cnt_ff <= 8'h00;
    end else begin
      src_cnt_ff  <= in_src ? src_cnt_ff + 8'h01 : 8'h00;
      meas_cnt_ff <= in_meas ? meas_cnt_ff + 8'h01 : 8'h00;
    end
  end
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence rd_req;
    rd_take;
  endsequence
  sequence rd_answer;
    !hreadyout ##1 hreadyout;
  endsequence
  hresp_okay_a: assert property (hresp == 1'b0)
    else $error("hresp not okay");
  read_wait_a: assert property (rd_req |=> rd_answer)
    else $error("read wait state wrong");
  wait_cause_a: assert property ($fell(hreadyout) |-> $past(rd_take))
    else $error("wait state without read");
  strobe_pulse_a: assert property (seq_sig.meas_strobe |=> !seq_sig.meas_strobe)
    else $error("measure strobe too long");
  lamp_running_a: assert property (seq_sig.busy |-> seq_sig.lamp)
    else $error("lamp dark while running");
  src_order_a: assert property ($past(in_src) && !in_src && seq_sig.busy |-> seq_sig.phase == PH_DELAY)
    else $error("source not followed by delay");
  src_time_a: assert property ($past(in_src) && seq_sig.phase == PH_DELAY |-> src_cnt_ff == 8'(SRC_CYC))
    else $error("source phase length wrong");
  meas_time_a: assert property (seq_sig.meas_strobe |-> meas_cnt_ff == 8'(MEAS_CYC))
    else $error("measure phase length wrong");
  err_cause_a: assert property ($rose(seq_sig.trig_err) |-> $past(seq_sig.busy))
    else $error("error raised while not busy");
  reset_idle_a: assert property (disable iff (1'b0) !rst_n |=> !seq_sig.busy && !seq_sig.trig_err && seq_sig.at_bias)
    else $error("reset state wrong");
endmodule
bind its_seq its_seq_properties #(.BLINK_HALF(BLINK_HALF)) i_its_seq_properties (
  .clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .trig_in_n(trig_in_n), .button_n(button_n), .seq_sig(seq_sig)
);

/* testbench/its_trig_src.sv */
// trigger source model: front button and rear pulse input
// assumes clk is the sequencer clock; both pins rest high
`timescale 1ns/1ns
module its_trig_src (
  // clock
  input  wire logic clk,
  // pins
  output logic      trig_in_n,
  output logic      button_n
);
  initial begin
    trig_in_n = 1'b1;
    button_n  = 1'b1;
  end
  // ---------------------------------------------------------------
  // low pulse of three clocks, then three clocks high
  // ---------------------------------------------------------------
  task automatic pulse(input logic ext);
    if (ext) trig_in_n <= 1'b0;
    else button_n <= 1'b0;
    repeat (3) @(posedge clk);
    trig_in_n <= 1'b1;
    button_n  <= 1'b1;
    repeat (3) @(posedge clk);
  endtask
endmodule

/* testbench/tb.sv */
// self-checking bench of the input trigger sequencer
// assumes the checker is bound in and the trigger model drives the pins
`timescale 1ns/1ns
module tb
  import its_pkg::*;
;
  logic        clk;
  logic        rst_n;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        trig_in_n;
  logic        button_n;
  its_out_s    seq_sig;
  logic [31:0] seed;
  logic [31:0] v;
  logic [15:0] s;
  logic [15:0] st;
  logic        lp;
  int          fails;
  int          compares;
  int          cycles;
  int          tn;
  int          n;
  int          t;
  its_seq #(.BLINK_HALF(8)) i_its_seq (
    .clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .trig_in_n(trig_in_n), .button_n(button_n), .seq_sig(seq_sig)
  );
  its_trig_src i_its_trig_src (.clk(clk), .trig_in_n(trig_in_n), .button_n(button_n));
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [31:0] ctl(input int m, input logic sw, input logic op, input logic en);
    return {24'h0, 1'b1, en, op, sw, 4'(m)};
  endfunction
  // triggers until the first (k=0) or next (k=1) measurement
  function automatic int need(input int m, input int k);
    case (m)
      1: return 1;
      2, 4: return k ? 1 : 2;
      3, 5: return 2;
      6: return k ? 2 : 3;
      default: return 3;
    endcase
  endfunction
  task automatic conclude();
    $display("checks %0d mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic fin();
    tn++;
    $display("test %0d done", tn);
  endtask
  task automatic settle();
    repeat (3) @(posedge clk);
  endtask
  task automatic count_meas(input int want);
    n = 0;
    for (t = 0; t < 1000 && n < want; t++) begin
      @(posedge clk);
      if (seq_sig.meas_strobe === 1'b1) n++;
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    v = hrdata;
  endtask
  task automatic fire();
    seed = lfsr(seed);
    case (seed[1:0])
      2'h0: i_its_trig_src.pulse(1'b1);
      2'h1: i_its_trig_src.pulse(1'b0);
      default: xfer(1'b1, REG_TRIG, 32'h1);
    endcase
  endtask
  // one trigger, plus a second button pulse 5 clocks later when col is set, then count measurements until the sequencer rests
  task automatic go(input logic col, output int cnt);
    int idle;
    cnt = 0;
    idle = 0;
    fire();
    if (col) begin
      repeat (5) @(posedge clk);
      i_its_trig_src.pulse(1'b0);
    end
    while (idle < 12) begin
      @(posedge clk);
      idle = (seq_sig.busy === 1'b1) ? 0 : idle + 1;
      if (seq_sig.meas_strobe === 1'b1) cnt++;
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      fails++;
      conclude();
    end
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    rst_n = 1'b0;
    seed = 32'hE273;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    xfer(1'b0, REG_CTRL, 32'h0);
    chk(v, {24'h0, CTRL_RST});
    xfer(1'b0, REG_POINTS, 32'h0);
    chk(v, {16'h0, POINTS_RST});
    xfer(1'b0, 8'h30, 32'h0);
    chk(v, 32'h0);
    chk({31'h0, seq_sig.at_bias}, 32'h1);
    fin();
    xfer(1'b1, REG_CTRL, ctl(0, 1'b0, 1'b1, 1'b1));
    count_meas(1);
    chk(32'(n), 32'h1);
    xfer(1'b1, REG_CTRL, ctl(0, 1'b0, 1'b0, 1'b0));
    seed = lfsr(seed);
    s = seed[15:0];
    st = seed[31:16];
    xfer(1'b1, REG_DELAY, {28'h0, seed[19:16]});
    xfer(1'b1, REG_SRC, {16'h0, s});
    xfer(1'b1, REG_CTRL, ctl(1, 1'b0, 1'b0, 1'b1));
    chk({16'h0, seq_sig.src_level}, 32'h0);
    go(1'b0, n);
    chk(32'(n), 32'h1);
    chk({16'h0, seq_sig.src_level}, {16'h0, s});
    xfer(1'b1, REG_SRC, {16'h0, ~s});
    settle();
    chk({31'h0, seq_sig.display_blank}, 32'h1);
    chk({16'h0, seq_sig.src_level}, {16'h0, s});
    go(1'b0, n);
    chk({16'h0, seq_sig.src_level}, {16'h0, ~s});
    chk({31'h0, seq_sig.display_blank}, 32'h0);
    xfer(1'b1, REG_TRIG, 32'h2);
    settle();
    chk({31'h0, seq_sig.display_blank}, 32'h1);
    fin();
    go(1'b1, n);
    chk(32'(n), 32'h1);
    chk({31'h0, seq_sig.trig_err}, 32'h1);
    xfer(1'b1, REG_TRIG, 32'h4);
    settle();
    chk({31'h0, seq_sig.trig_err}, 32'h0);
    fin();
    for (int m = 1; m < 8; m++) begin
      xfer(1'b1, REG_CTRL, ctl(m, 1'b0, 1'b0, 1'b1));
      for (int k = 0; k < 2; k++) begin
        t = 0;
        n = 0;
        while (n == 0 && t < 4) begin
          go(1'b0, n);
          t++;
        end
        chk(32'(t), 32'(need(m, k)));
        chk(32'(n), 32'h1);
      end
    end
    fin();
    xfer(1'b1, REG_STEP, {16'h0, st});
    xfer(1'b1, REG_BIAS, {16'h0, s ^ 16'h5A5A});
    xfer(1'b1, REG_POINTS, 32'h2);
    xfer(1'b1, REG_CTRL, ctl(1, 1'b1, 1'b0, 1'b1));
    for (int i = 0; i < 3; i++) begin
      go(1'b0, n);
      chk(32'(n), (i < 2) ? 32'h1 : 32'h0);
      chk({16'h0, seq_sig.src_level}, {16'h0, (i < 2) ? 16'(~s + 16'(i) * st) : s ^ 16'h5A5A});
      chk({31'h0, seq_sig.at_bias}, (i < 2) ? 32'h0 : 32'h1);
      chk({16'h0, seq_sig.meas_point}, (i < 2) ? 32'(i) : 32'h1);
    end
    fin();
    for (int i = 0; i < 2; i++) begin
      xfer(1'b1, REG_POINTS, 32'(3 + i));
      xfer(1'b1, REG_CTRL, ctl(i ? 8 : 0, 1'b1, 1'b0, 1'b1));
      go(1'b0, n);
      chk(32'(n), i ? 32'h2 : 32'h3);
    end
    fin();
    xfer(1'b1, REG_CTRL, ctl(8, 1'b0, 1'b1, 1'b0));
    fire();
    repeat (20) @(posedge clk);
    chk({30'h0, seq_sig.busy, seq_sig.lamp}, 32'h0);
    xfer(1'b1, REG_CTRL, ctl(8, 1'b0, 1'b1, 1'b1));
    n = 0;
    lp = seq_sig.lamp;
    for (int i = 0; i < 32; i++) begin
      @(posedge clk);
      if (seq_sig.lamp !== lp) n++;
      lp = seq_sig.lamp;
    end
    chk({31'h0, seq_sig.busy}, 32'h0);
    chk(32'(n > 1), 32'h1);
    fire();
    count_meas(2);
    chk(32'(n), 32'h2);
    xfer(1'b1, REG_CTRL, ctl(8, 1'b0, 1'b1, 1'b0));
    settle();
    chk({30'h0, seq_sig.busy, seq_sig.lamp}, 32'h0);
    fin();
    conclude();
  end
endmodule
